/* File: acq_io_control.sv */
// Acquisition control: digital port, gate line, systems, event time packing
`default_nettype none
module acq_io_control (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [acq_io_pkg::NSYS-1:0] start_cmd,
  input wire logic [acq_io_pkg::NSYS-1:0] stop_cmd,
  input wire logic [acq_io_pkg::NSYS-1:0] preset_hit,
  input wire logic [1:0] gate_sys,
  input wire logic status_mode,
  input wire logic stop_counter_output,
  input wire logic [7:0] stop_count_init,
  input wire logic stop_count_load,
  input wire logic invert,
  input wire logic open_drain,
  input wire logic ext_start_en,
  input wire logic gate_start_en,
  input wire logic erase_before_launch,
  input wire logic gate_raise_on_run,
  input wire logic gate_drop_on_halt,
  input wire logic tag_en,
  input wire logic width_en,
  input wire logic fine_time,
  input wire logic reject_en,
  input wire logic [11:0] width_limit,
  input wire logic [acq_io_pkg::PORT_W-1:0] dio_in,
  input wire logic gate_in,
  input wire logic above_thr,
  input wire logic event_strobe,
  input wire logic [acq_io_pkg::NSCALER-1:0] scaler_in,
  input wire logic [2:0] scaler_sel,
  output logic [acq_io_pkg::PORT_W-1:0] dio_out,
  output logic [acq_io_pkg::PORT_W-1:0] dio_oe_n,
  output logic gate_out,
  output logic gate_oe_n,
  output logic [acq_io_pkg::NSYS-1:0] sys_running,
  output logic [acq_io_pkg::NSYS-1:0] sys_erase,
  output logic event_valid,
  output logic [acq_io_pkg::TIME_W-1:0] event_time,
  output logic event_histo,
  output logic [acq_io_pkg::SCALER_W-1:0] scaler_value
);
  typedef acq_io_pkg::sys_state_t [acq_io_pkg::NSYS-1:0] sys_arr_t;
  typedef struct packed {
    sys_arr_t st;
    logic [1:0] ext_s1;
    logic ext_prev;
    logic [1:0] gte_s1;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [3:0] armed;
    logic [7:0] stop_cnt;
    logic [acq_io_pkg::PRE_W-1:0] tick_div;
    logic [acq_io_pkg::TIME_W-1:0] tstamp;
    logic [3:0] wdiv;
    logic [11:0] wcnt;
    logic [11:0] wlast;
    logic in_pulse;
    logic [7:0] dio;
    logic [7:0] dio_oe_n;
    logic gate;
    logic gate_oe_n;
    logic [3:0] running;
    logic [3:0] erase;
    logic ev_v;
    logic [acq_io_pkg::TIME_W-1:0] ev_t;
    logic ev_h;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [11:0] sat_inc(input logic [11:0] v);
    return (v == acq_io_pkg::WIDTH_MAX) ? v : v + 12'h001;
  endfunction

  logic ext_lvl;
  logic gte_lvl;
  logic run_sel;
  logic [acq_io_pkg::SCALER_W-1:0] scal_rd;
  logic [7:0] port_val;
  logic [11:0] wnow;

  always_comb begin
    d = q;
    // Synchronisers: first stage feeds only second stage
    d.ext_s1 = {q.ext_s1[0], dio_in[acq_io_pkg::EXT_PIN]};
    d.gte_s1 = {q.gte_s1[0], gate_in};
    d.pin_s1 = dio_in;
    d.pin_s2 = q.pin_s1;
    ext_lvl = q.ext_s1[1] ^ invert;
    gte_lvl = q.gte_s1[1];
    d.ext_prev = ext_lvl;
    d.erase = '0;
    d.ev_v = 1'b0;
    run_sel = (ext_start_en && !tag_en) || gate_start_en;
    for (int s = 0; s < acq_io_pkg::NSYS; s++) begin
      case (q.st[s])
        acq_io_pkg::SYS_IDLE: begin
          if (start_cmd[s]) begin
            if (run_sel) begin
              d.st[s] = acq_io_pkg::SYS_ARMED;
            end else begin
              d.st[s] = erase_before_launch ? acq_io_pkg::SYS_CLEAR
                                            : acq_io_pkg::SYS_RUN;
            end
          end
        end
        acq_io_pkg::SYS_ARMED: begin
          if (stop_cmd[s]) begin
            d.st[s] = acq_io_pkg::SYS_IDLE;
          end else if (gate_start_en && gte_lvl) begin
            d.st[s] = acq_io_pkg::SYS_CLEAR;
          end else if (!gate_start_en && q.ext_prev && !ext_lvl) begin
            d.st[s] = acq_io_pkg::SYS_CLEAR;
          end
        end
        acq_io_pkg::SYS_CLEAR: begin
          d.erase[s] = 1'b1;
          d.st[s] = stop_cmd[s] ? acq_io_pkg::SYS_IDLE : acq_io_pkg::SYS_RUN;
        end
        default: begin
          if (stop_cmd[s]) begin
            d.st[s] = acq_io_pkg::SYS_IDLE;
          end else if (preset_hit[s]) begin
            d.st[s] = run_sel ? acq_io_pkg::SYS_ARMED : acq_io_pkg::SYS_IDLE;
          end else if (gate_start_en && !gte_lvl) begin
            d.st[s] = acq_io_pkg::SYS_ARMED;
          end else if (!gate_start_en && ext_start_en && !tag_en && ext_lvl) begin
            d.st[s] = acq_io_pkg::SYS_ARMED;
          end
        end
      endcase
    end
    // Run flag rises one cycle after the erase pulse on a launch through SYS_CLEAR, so nothing counts into stale data; an IDLE-to-RUN launch has no erase pulse
    for (int s = 0; s < acq_io_pkg::NSYS; s++) begin
      d.running[s] = (d.st[s] == acq_io_pkg::SYS_RUN)
                     && (q.st[s] != acq_io_pkg::SYS_CLEAR);
    end
    // Counter bumps once in each cycle where any system's run flag falls
    if (stop_count_load) begin
      d.stop_cnt = stop_count_init;
    end else if (|(q.running & ~d.running)) begin
      d.stop_cnt = q.stop_cnt + 8'h01;
    end
    // Port drive
    port_val = status_mode ? {4'h0, q.running} : q.stop_cnt;
    if (tag_en || !(status_mode || stop_counter_output)) begin
      d.dio = 8'h00;
      d.dio_oe_n = 8'hFF;
    end else begin
      for (int b = 0; b < acq_io_pkg::PORT_W; b++) begin
        d.dio[b] = port_val[b] ^ invert;
        d.dio_oe_n[b] = open_drain ? d.dio[b] : 1'b0;
      end
      if (ext_start_en) begin
        d.dio_oe_n[acq_io_pkg::EXT_PIN] = 1'b1; // Input 4 stays an input
      end
    end
    // Gate line: hardware drop on preset beats the raise
    if (gate_drop_on_halt && (preset_hit[gate_sys] || stop_cmd[gate_sys])) begin
      d.gate = 1'b0;
    end else begin
      d.gate = gate_raise_on_run && d.running[gate_sys];
    end
    d.gate_oe_n = gate_start_en || !(gate_raise_on_run || gate_drop_on_halt);
    // Time base
    // Compare with >= so a switch to the short tick does not wait for a wrap
    if (q.tick_div >= 20'(fine_time ? acq_io_pkg::FINE_CYC - 1 : acq_io_pkg::COARSE_CYC - 1)) begin
      d.tick_div = acq_io_pkg::TICK_RST;
      d.tstamp = q.tstamp + 44'h00000000001;
    end else begin
      d.tick_div = q.tick_div + 20'h00001;
    end
    // Width in quanta of WIDTH_STEP_CYC = 1 clock (100 ns at CLK_HZ), saturating
    wnow = q.wcnt;
    if (above_thr) begin
      d.in_pulse = 1'b1;
      if (!q.in_pulse) begin
        d.wcnt = 12'h000;
        d.wdiv = 4'h0;
      end else if (q.wdiv == 4'(acq_io_pkg::WIDTH_STEP_CYC - 1)) begin
        d.wdiv = 4'h0;
        d.wcnt = sat_inc(q.wcnt);
      end else begin
        d.wdiv = q.wdiv + 4'h1;
      end
    end else begin
      d.in_pulse = 1'b0;
      if (q.in_pulse) begin
        d.wlast = q.wcnt;
      end
    end
    wnow = q.in_pulse ? q.wcnt : q.wlast;
    if (event_strobe) begin
      d.ev_v = 1'b1;
      d.ev_t = q.tstamp;
      if (tag_en) begin
        d.ev_t[43:36] = q.pin_s2;
      end else if (width_en) begin
        d.ev_t = {wnow, q.tstamp[31:0]};
      end
      d.ev_h = !(width_en && reject_en && (wnow > width_limit));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.dio_oe_n <= 8'hFF;
      q.gate_oe_n <= 1'b1;
      q.stop_cnt <= acq_io_pkg::STOPCNT_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  scaler_bank u_scal (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .clear(|q.erase),
    .gate(q.gate),
    .cnt_in(scaler_in),
    .rd_sel(scaler_sel),
    .rd_data(scal_rd)
  );

  assign dio_out = q.dio;
  assign dio_oe_n = q.dio_oe_n;
  assign gate_out = q.gate;
  assign gate_oe_n = q.gate_oe_n;
  assign sys_running = q.running;
  assign sys_erase = q.erase;
  assign event_valid = q.ev_v;
  assign event_time = q.ev_t;
  assign event_histo = q.ev_h;
  assign scaler_value = scal_rd;

  property p_erase_then_run;
    @(posedge clk) disable iff (srst)
    (ce && q.erase[0] && !stop_cmd[0] && !preset_hit[0] && !ext_start_en && !gate_start_en)
      |=> q.running[0];
  endproperty
  a_erase_then_run: assert property (p_erase_then_run) else $error("erase not followed by run");

  property p_tag_port_off;
    @(posedge clk) disable iff (srst)
    (ce && tag_en) |=> (dio_oe_n == 8'hFF || !$past(tag_en));
  endproperty
  a_tag_port_off: assert property (p_tag_port_off) else $error("port driven in tag mode");

  property p_stop_disarms;
    @(posedge clk) disable iff (srst)
    (ce && stop_cmd[0] && q.st[0] != acq_io_pkg::SYS_CLEAR) |=> !q.running[0];
  endproperty
  a_stop_disarms: assert property (p_stop_disarms) else $error("stop did not halt system");

  property p_histo_reject;
    @(posedge clk) disable iff (srst)
    event_valid |-> (event_histo || (width_en && reject_en));
  endproperty
  a_histo_reject: assert property (p_histo_reject) else $error("event wrongly rejected");

  sequence s_ext_fall;
    ce && !stop_cmd[0] && !gate_start_en && q.st[0] == acq_io_pkg::SYS_ARMED
      && q.ext_prev && !ext_lvl;
  endsequence

  sequence s_clear_step;
    ce && q.st[0] == acq_io_pkg::SYS_CLEAR;
  endsequence

  property p_ext_launch;
    @(posedge clk) disable iff (srst)
    (s_ext_fall ##1 s_clear_step) |=> (q.erase[0] && !q.running[0]);
  endproperty
  a_ext_launch: assert property (p_ext_launch) else $error("external start skipped the clear");

  property p_gate_drop;
    @(posedge clk) disable iff (srst)
    (ce && gate_drop_on_halt && (stop_cmd[gate_sys] || preset_hit[gate_sys])) |=> !gate_out;
  endproperty
  a_gate_drop: assert property (p_gate_drop) else $error("gate held after halt");

  property p_status_port;
    @(posedge clk) disable iff (srst)
    (ce && status_mode && !tag_en) |=> (dio_out[0] == ($past(q.running[0]) ^ $past(invert)));
  endproperty
  a_status_port: assert property (p_status_port) else $error("status pin wrong");
endmodule
`default_nettype wire

/* File: acq_io_pkg.sv */
// Package of constants and types for the acquisition I/O control block
`default_nettype none
package acq_io_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // Width quantum in ns and its cycle count (rounded down, at least one)
  localparam int unsigned WIDTH_STEP_NS = 64;
  localparam int unsigned WIDTH_STEP_RAW = WIDTH_STEP_NS / CLK_NS;
  localparam int unsigned WIDTH_STEP_CYC = (WIDTH_STEP_RAW < 1) ? 1 : WIDTH_STEP_RAW;
  // Time-field unit: one 100 ns clock with fine option (8 ns clamped to FINE_CYC = 1), else 1 ms
  localparam int unsigned FINE_TICK_NS = 8;
  localparam int unsigned COARSE_TICK_NS = 1_000_000;
  localparam int unsigned FINE_RAW = FINE_TICK_NS / CLK_NS;
  localparam int unsigned FINE_CYC = (FINE_RAW < 1) ? 1 : FINE_RAW;
  localparam int unsigned COARSE_CYC = COARSE_TICK_NS / CLK_NS;
  localparam int unsigned NSYS = 4;
  localparam int unsigned NSCALER = 8;
  localparam int unsigned SCALER_W = 32;
  localparam int unsigned TIME_W = 44;
  localparam int unsigned SHORT_TIME_W = 32;
  localparam int unsigned WIDTH_W = 12;
  localparam int unsigned TAG_W = 8;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned EXT_PIN = 4;
  localparam int unsigned PRE_W = 20;
  localparam logic [19:0] TICK_RST = 20'h00000;
  localparam logic [7:0] STOPCNT_RST = 8'h00;
  localparam logic [11:0] WIDTH_MAX = 12'hFFF;
  typedef enum logic [1:0] {
    SYS_IDLE = 2'b00,
    SYS_ARMED = 2'b01,
    SYS_CLEAR = 2'b10,
    SYS_RUN = 2'b11
  } sys_state_t;
endpackage
`default_nettype wire

/* File: acquisition_io_control_tb_top.sv */
// Self-checking testbench of the acquisition I/O control block
`default_nettype none
module acquisition_io_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] start_cmd = 4'h0, stop_cmd = 4'h0;
  logic status_mode = 1'b1, stop_counter_output = 1'b0, stop_count_load = 1'b0;
  logic invert = 1'b0, open_drain = 1'b0, ext_start_en = 1'b0, erase_before_launch = 1'b0;
  logic gate_raise_on_run = 1'b1, gate_drop_on_halt = 1'b1, tag_en = 1'b0, width_en = 1'b0;
  logic reject_en = 1'b0, above_thr = 1'b0, event_strobe = 1'b0, run = 1'b0;
  logic [7:0] stop_count_init = 8'h00, scaler_in = 8'h01, tag = 8'h10, dio_in, exp8;
  logic [1:0] gate_sys = 2'h0;
  logic [2:0] scaler_sel = 3'h0;
  logic [11:0] width_limit = 12'h000, w;
  logic gate_in;
  logic [7:0] dio_out, dio_oe_n;
  logic gate_out, gate_oe_n, event_valid, event_histo;
  logic [3:0] sys_running, sys_erase;
  logic [43:0] event_time;
  logic [43:0] t1;
  logic [3:0] preset_hit = 4'h0;
  logic gate_start_en = 1'b0, fine_time = 1'b0;
  logic [31:0] scaler_value;
  logic [31:0] seed = 32'hEDACE08A;
  int error_cnt = 0;
  int checks_done = 0;
  int k, n;

  always #50 clk = ~clk;

  acq_io_control DUT (.clk(clk), .srst(srst), .ce(1'b1), .start_cmd(start_cmd),
    .stop_cmd(stop_cmd), .preset_hit(preset_hit), .gate_sys(gate_sys), .status_mode(status_mode),
    .stop_counter_output(stop_counter_output), .stop_count_init(stop_count_init),
    .stop_count_load(stop_count_load), .invert(invert), .open_drain(open_drain),
    .ext_start_en(ext_start_en), .gate_start_en(gate_start_en),
    .erase_before_launch(erase_before_launch), .gate_raise_on_run(gate_raise_on_run),
    .gate_drop_on_halt(gate_drop_on_halt), .tag_en(tag_en), .width_en(width_en),
    .fine_time(fine_time), .reject_en(reject_en), .width_limit(width_limit), .dio_in(dio_in),
    .gate_in(gate_in), .above_thr(above_thr), .event_strobe(event_strobe),
    .scaler_in(scaler_in), .scaler_sel(scaler_sel), .dio_out(dio_out), .dio_oe_n(dio_oe_n),
    .gate_out(gate_out), .gate_oe_n(gate_oe_n), .sys_running(sys_running),
    .sys_erase(sys_erase), .event_valid(event_valid), .event_time(event_time),
    .event_histo(event_histo), .scaler_value(scaler_value));

  run_ctrl_model ctrl (.clk(clk), .run(run), .tag(tag), .dio(dio_in), .gate(gate_in));

  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Status pins: run flags of systems 0..3, flipped by the polarity option
  function automatic logic [3:0] status_exp(input logic [3:0] run_flags, input logic inv);
    return run_flags ^ {4{inv}};
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [43:0] seen, input logic [43:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask

  // Bounded wait on a condition sampled once per cycle; a stall ends the run
  task automatic wait_for(input string what, input int sel, input logic v);
    int i;
    for (i = 0; i < 30; i++) begin
      if ((sel == 0 ? sys_running[0] : sel == 1 ? sys_erase[0] : event_valid) === v) begin
        return;
      end
      @(negedge clk);
    end
    error_cnt++;
    $display("Error timeout waiting for %s", what);
    end_of_test();
  endtask

  task automatic cmd(input logic st, input logic [3:0] m);
    if (st) start_cmd = m;
    else stop_cmd = m;
    cyc(1);
    start_cmd = 4'h0;
    stop_cmd = 4'h0;
  endtask

  task automatic evt();
    event_strobe = 1'b1;
    cyc(1);
    event_strobe = 1'b0;
    wait_for("event", 2, 1'b1);
  endtask

  initial begin
    cyc(16);
    chk("rst_oe", dio_oe_n, 8'hFF);
    chk("rst_run", sys_running, 4'h0);
    srst = 1'b0;
    cyc(2);
    for (k = 0; k < 4; k++) begin
      invert = k[0];
      open_drain = k[1];
      cmd(1'b1, 4'h1);
      wait_for("run", 0, 1'b1);
      cyc(3);
      chk("status", dio_out[3:0], status_exp(4'h1, k[0]));
      chk("oe", dio_oe_n[0], k[1] & ~k[0]);
      chk("gate_hi", gate_out, 1'b1);
      chk("gate_oe", gate_oe_n, 1'b0);
      cmd(1'b0, 4'h1);
      wait_for("stop", 0, 1'b0);
      cyc(2);
      chk("gate_lo", gate_out, 1'b0);
      chk("idle", dio_out[3:0], status_exp(4'h0, k[0]));
    end
    invert = 1'b0;
    open_drain = 1'b0;
    $display("test status done");
    cmd(1'b1, 4'h6);
    cyc(3);
    chk("group", sys_running, 4'h6);
    cmd(1'b0, 4'hF);
    erase_before_launch = 1'b1;
    cmd(1'b1, 4'h1);
    wait_for("erase", 1, 1'b1);
    chk("pre_erase", sys_running[0], 1'b0);
    wait_for("run", 0, 1'b1);
    cyc(10);
    cmd(1'b0, 4'h1);
    wait_for("stop", 0, 1'b0);
    cyc(3);
    // Gate high from the edge after the clear up to the stop edge: 11 counts
    chk("scal_run", scaler_value, 32'h0000000B);
    cyc(8);
    chk("scal_hold", scaler_value, 32'h0000000B);
    cmd(1'b1, 4'h1);
    wait_for("run", 0, 1'b1);
    cyc(2);
    preset_hit = 4'h1;
    cyc(1);
    preset_hit = 4'h0;
    chk("preset_gate", gate_out, 1'b0);
    chk("preset_idle", sys_running[0], 1'b0);
    erase_before_launch = 1'b0;
    status_mode = 1'b0;
    stop_counter_output = 1'b1;
    for (k = 0; k < 2; k++) begin
      seed = xorshift(seed);
      exp8 = k ? 8'hFF : seed[7:0];
      stop_count_init = exp8;
      stop_count_load = 1'b1;
      cyc(1);
      stop_count_load = 1'b0;
      cmd(1'b1, 4'h1);
      wait_for("run", 0, 1'b1);
      cmd(1'b0, 4'h1);
      cyc(4);
      chk("stop_cnt", dio_out, 8'(exp8 + 8'h01));
    end
    $display("test counter done");
    stop_counter_output = 1'b0;
    status_mode = 1'b1;
    ext_start_en = 1'b1;
    cmd(1'b1, 4'h1);
    cyc(6);
    chk("armed", sys_running[0], 1'b0);
    for (k = 0; k < 2; k++) begin
      run = 1'b1;
      wait_for("ext_erase", 1, 1'b1);
      chk("clear_first", sys_running[0], 1'b0);
      wait_for("ext_run", 0, 1'b1);
      run = 1'b0;
      wait_for("ext_stop", 0, 1'b0);
    end
    cmd(1'b0, 4'h1);
    cyc(2);
    run = 1'b1;
    cyc(10);
    chk("disarmed", sys_running[0], 1'b0);
    run = 1'b0;
    ext_start_en = 1'b0;
    gate_start_en = 1'b1;
    cmd(1'b1, 4'h1);
    cyc(4);
    chk("gate_in_mode", gate_oe_n, 1'b1);
    chk("gate_armed", sys_running[0], 1'b0);
    run = 1'b1;
    wait_for("go_run", 0, 1'b1);
    run = 1'b0;
    wait_for("go_stop", 0, 1'b0);
    cmd(1'b0, 4'h1);
    gate_start_en = 1'b0;
    $display("test external done");
    width_en = 1'b1;
    reject_en = 1'b1;
    for (k = 0; k < 2; k++) begin
      seed = xorshift(seed);
      n = 10 + int'(seed[3:0]);
      width_limit = k ? 12'h064 : 12'h005;
      above_thr = 1'b1;
      cyc(n);
      above_thr = 1'b0;
      cyc(2);
      evt();
      w = event_time[43:32];
      chk("width", (w + 12'h001 >= n[11:0]) && (w <= n[11:0] + 12'h001), 1'b1);
      chk("histo", event_histo, k[0]);
    end
    width_en = 1'b0;
    fine_time = 1'b1;
    cyc(3);
    evt();
    t1 = event_time;
    cyc(7);
    evt();
    // Strobes eight edges apart, one tick per FINE_CYC cycles
    chk("tick", event_time - t1, 44'(8 / acq_io_pkg::FINE_CYC));
    fine_time = 1'b0;
    tag_en = 1'b1;
    seed = xorshift(seed);
    tag = seed[7:0];
    cyc(5);
    evt();
    chk("tag", event_time[43:36], tag);
    chk("tag_oe", dio_oe_n, 8'hFF);
    $display("test event done");
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: run_ctrl_model.sv */
// Model of the external run controller facing the digital port
`default_nettype none
module run_ctrl_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] tag,
  output var logic [7:0] dio = 8'h10,
  output var logic gate = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins change just after a rising edge, as a clocked controller would
  always @(posedge clk) begin
    dio <= tag ^ {3'h0, run, 4'h0};
    gate <= run;
  end
endmodule
`default_nettype wire

/* File: scaler_bank.sv */
// Bank of eight gated scaler counters with registered read port
`default_nettype none
module scaler_bank (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic clear,
  input wire logic gate,
  input wire logic [acq_io_pkg::NSCALER-1:0] cnt_in,
  input wire logic [2:0] rd_sel,
  output logic [acq_io_pkg::SCALER_W-1:0] rd_data
);
  typedef struct packed {
    logic [acq_io_pkg::NSCALER-1:0][acq_io_pkg::SCALER_W-1:0] cnt;
    logic [acq_io_pkg::SCALER_W-1:0] rd;
  } bank_t;
  bank_t s_q;
  bank_t s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < acq_io_pkg::NSCALER; i++) begin
      if (clear) begin
        s_d.cnt[i] = '0;
      end else if (gate && cnt_in[i]) begin
        s_d.cnt[i] = s_q.cnt[i] + 32'h00000001;
      end
    end
    s_d.rd = s_q.cnt[rd_sel];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd;
endmodule
`default_nettype wire
